/* shared/cpa_defines.svh */
// constants of the configuration port access block
`ifndef CPA_DEFINES_SVH
`define CPA_DEFINES_SVH
`define CPA_KEY_UNLOCK     8'h55
`define CPA_KEY_LOCK       8'hAA
`define CPA_IDX_CTRL       8'h02
`define CPA_IDX_LDN        8'h07
`define CPA_IDX_DEVID      8'h20
`define CPA_IDX_DEVREV     8'h21
`define CPA_IDX_PWRCTL     8'h22
`define CPA_IDX_PWRMGT     8'h23
`define CPA_IDX_OSC        8'h24
`define CPA_IDX_ADDR_LO    8'h26
`define CPA_IDX_ADDR_HI    8'h27
`define CPA_IDX_ACTIVATE   8'h30
`define CPA_IDX_LD_BASE    8'h60
`define CPA_CTRL_SOFT_BIT  0
`define CPA_RST_ADDR_LO_S0 8'hF0
`define CPA_RST_ADDR_LO_S1 8'h70
`define CPA_RST_ADDR_HI    8'h03
`define CPA_RST_OSC        8'h04
`define CPA_RST_LDN        8'h00
`define CPA_OPEN_BUS       8'hFF
`define CPA_CAP_WAIT       2'h3
`define CPA_CLK_PERIOD_NS  100
`define CPA_POR_BLOCK_US   500
`define CPA_POR_BLOCK_CYC  ((`CPA_POR_BLOCK_US * 1000) / `CPA_CLK_PERIOD_NS)
`endif

/* shared/cpa_pkg.sv */
// types of the configuration port access block
package cpa_pkg;
   // access controller has exactly two states
   typedef enum logic {
      CPA_RUN = 1'b0,   // normal operation, only the unlock key is heard
      CPA_CFG = 1'b1    // index and data ports open
   } cpa_mode_e;
   typedef logic [7:0] cpa_byte_t;   // one register byte
endpackage

/* core/cpa_top.sv */
// configuration port access: key lock, index/data ports, global and per-device registers
//
// How it works
// R1: reset gives run state, devices disabled
// R2: strap latched at bus reset fall or power-on
// R3: strap low 0x03F0, high 0x0370 base
// R4: relocation bytes move the port base
// R5: address enable high cycles are ignored
// R6: index/data ports live only in config state
// R7: key 0x55 enters configuration state
// R8: key 0xAA returns to run state
// R9: index at base, data at base plus one
// R10: host selects device via index 0x07 first
// R11: data port reaches indexed register of device
// R12: globals reachable whatever device is selected
// R13: host unlocks, accesses, then locks
// R14: two states only, run always hears unlock
// R15: control bit 0 soft reset; pin hard reset
// R16: key port write-only, index/data read-write
// R17: accesses blocked 500 us after power-on
// R18: relocation bytes reset from the strap
// R19: device number register resets to zero
// R20: other run-state key values are ignored
// R21: index held until rewritten
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`include "cpa_defines.svh"

module cpa_top #(
   parameter int        NUM_LD        = 10,                  // logical devices
   parameter int        LD_WIN        = 32,                  // bytes per device from 0x60
   parameter int        POR_BLOCK_CYC = `CPA_POR_BLOCK_CYC,  // cycles blocked after power-on
   parameter logic [7:0] DEV_ID       = 8'h5A,               // arbitrary value
   parameter logic [7:0] DEV_REV      = 8'h01                // arbitrary value
) (
   input  wire logic              mclk_i,              // 10 MHz block clock
   input  wire logic              rstn_i,              // power-on reset, sync, active low
   input  wire logic              bus_reset_input_i,   // hard reset pin, active high
   input  wire logic              strap_i,             // base select strap pin
   input  wire logic              aen_i,               // address enable, with request
   input  wire logic [15:0]       avs_address_i,       // host I/O address
   input  wire logic              avs_read_i,          // read request
   input  wire logic              avs_write_i,         // write request
   input  wire logic [7:0]        avs_writedata_i,     // write byte
   output logic      [7:0]        avs_readdata_o,      // read byte
   output logic                   avs_waitrequest_o,   // low for one cycle to answer
   output logic                   cfg_mode_o,          // high in configuration state
   output logic      [NUM_LD-1:0] ld_active_o,         // activate bit per device
   output logic      [15:0]       port_base_o          // current key/index port address
);
   // ----------------------------------------------------------------
   // parameters and state
   // ----------------------------------------------------------------
   localparam int CW  = 16;                  // block counter width
   localparam int LDW = (NUM_LD > 1) ? $clog2(NUM_LD) : 1;
   localparam int LWW = (LD_WIN > 1) ? $clog2(LD_WIN) : 1;

   // refuse shapes the decode cannot serve
   if (NUM_LD < 1 || NUM_LD > 256 || LD_WIN < 1 || LD_WIN > 160 ||
       POR_BLOCK_CYC < 1 || POR_BLOCK_CYC >= 65536) begin : g_bad
      $error("cpa_top: parameter out of range");
   end

   typedef struct packed {
      cpa_pkg::cpa_mode_e                  mode;    // run or config
      logic [7:0]                          idx;     // index port value
      logic [7:0]                          ldn;     // selected logical device
      logic [7:0]                          pwrctl;  // power control
      logic [7:0]                          pwrmgt;  // power management
      logic [7:0]                          osc;     // oscillator control
      logic [7:0]                          alo;     // key_port_addr_low
      logic [7:0]                          ahi;     // key_port_addr_high
      logic                                strap;   // latched strap
      logic [1:0]                          brst_sy; // bus reset synchroniser
      logic [1:0]                          strp_sy; // strap synchroniser
      logic                                brst_pv; // synced reset, one cycle old
      logic [1:0]                          cap;     // wait before power-on strap capture
      logic [CW-1:0]                       blk;     // power-on block countdown
      logic                                wreq;    // registered waitrequest
      logic [7:0]                          rdata;   // registered read data
      logic [NUM_LD-1:0][7:0]              act;     // activate register per device
      logic [NUM_LD-1:0][LD_WIN-1:0][7:0]  mem;     // per-device registers
   } cpa_state_s;

   cpa_state_s s_q;   // registered state
   cpa_state_s s_d;   // next state

   logic       hard;     // synced bus reset asserted
   logic       fall;     // synced bus reset just released
   logic       take;     // request taken this cycle
   logic       live;     // taken request may have an effect
   logic       hit_key;  // address is key/index port
   logic       hit_dat;  // address is data port
   logic       ld_ok;    // selected device exists
   logic [7:0] woff;     // index minus device window base

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   always_comb begin
      hard    = s_q.brst_sy[1];
      fall    = s_q.brst_pv & ~s_q.brst_sy[1];
      take    = (avs_read_i | avs_write_i) & s_q.wreq;
      // blocked window and reset keep the host out; aen marks dma cycles
      live    = ~aen_i & ~hard & (s_q.blk == '0);  // see R5 see R17
      hit_key = (avs_address_i == {s_q.ahi, s_q.alo});                 // see R4
      hit_dat = (avs_address_i == ({s_q.ahi, s_q.alo} + 16'h0001));    // see R9
      ld_ok   = ({24'h0000_00, s_q.ldn} < NUM_LD);
      woff    = s_q.idx - `CPA_IDX_LD_BASE;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // bus reset and strap pins pass two flops before anything reads them
      s_d.brst_sy = {s_q.brst_sy[0], bus_reset_input_i};
      s_d.strp_sy = {s_q.strp_sy[0], strap_i};
      s_d.brst_pv = s_q.brst_sy[1];
      s_d.wreq    = 1'b1;
      if (s_q.blk != '0) begin
         s_d.blk = s_q.blk - 16'h0001;
      end
      if (s_q.cap != 2'h0) begin
         s_d.cap = s_q.cap - 2'h1;
      end
      // strap capture once the synchroniser holds a true pin level
      if (fall || s_q.cap == 2'h1) begin
         s_d.strap = s_q.strp_sy[1];                                   // see R2
         s_d.alo   = s_q.strp_sy[1] ? `CPA_RST_ADDR_LO_S1
                                    : `CPA_RST_ADDR_LO_S0;             // see R3 see R18
         s_d.ahi   = `CPA_RST_ADDR_HI;                                 // see R18
      end
      if (take) begin
         // one wait state, then a single-cycle answer
         s_d.wreq  = 1'b0;
         s_d.rdata = `CPA_OPEN_BUS;
         if (live && avs_write_i && hit_key) begin
            if (s_q.mode == cpa_pkg::CPA_RUN) begin
               // run state hears only the unlock key
               if (avs_writedata_i == `CPA_KEY_UNLOCK) begin           // see R7 see R14 see R20
                  s_d.mode = cpa_pkg::CPA_CFG;
               end
            end else if (avs_writedata_i == `CPA_KEY_LOCK) begin
               s_d.mode = cpa_pkg::CPA_RUN;                            // see R8
            end else begin
               s_d.idx = avs_writedata_i;                              // see R9 see R21
            end
         end
         if (live && avs_write_i && hit_dat && s_q.mode == cpa_pkg::CPA_CFG) begin // see R6
            // globals ignore the device number
            case (s_q.idx)                                             // see R12
               `CPA_IDX_CTRL: begin
                  if (avs_writedata_i[`CPA_CTRL_SOFT_BIT]) begin       // see R15
                     s_d.ldn    = `CPA_RST_LDN;                        // see R19
                     s_d.pwrctl = 8'h00;
                     s_d.act    = '0;
                  end
               end
               `CPA_IDX_LDN:     s_d.ldn    = avs_writedata_i;         // see R11 see R19
               `CPA_IDX_PWRCTL:  s_d.pwrctl = avs_writedata_i;
               `CPA_IDX_PWRMGT:  s_d.pwrmgt = avs_writedata_i;
               `CPA_IDX_OSC:     s_d.osc    = avs_writedata_i;
               `CPA_IDX_ADDR_LO: s_d.alo    = avs_writedata_i;         // see R4
               `CPA_IDX_ADDR_HI: s_d.ahi    = avs_writedata_i;         // see R4
               default: begin
                  // per-device registers of the selected device
                  if (ld_ok && s_q.idx == `CPA_IDX_ACTIVATE) begin     // see R11
                     s_d.act[s_q.ldn[LDW-1:0]] = avs_writedata_i;
                  end else if (ld_ok && s_q.idx >= `CPA_IDX_LD_BASE &&
                               {24'h0000_00, woff} < LD_WIN) begin
                     s_d.mem[s_q.ldn[LDW-1:0]][woff[LWW-1:0]] = avs_writedata_i;
                  end
               end
            endcase
         end
         if (live && avs_read_i && s_q.mode == cpa_pkg::CPA_CFG) begin
            // key port is write-only; it reads back the index only as index port
            if (hit_key) begin
               s_d.rdata = s_q.idx;                                    // see R16
            end else if (hit_dat) begin
               case (s_q.idx)
                  `CPA_IDX_LDN:     s_d.rdata = s_q.ldn;
                  `CPA_IDX_DEVID:   s_d.rdata = DEV_ID;
                  `CPA_IDX_DEVREV:  s_d.rdata = DEV_REV;
                  `CPA_IDX_PWRCTL:  s_d.rdata = s_q.pwrctl;
                  `CPA_IDX_PWRMGT:  s_d.rdata = s_q.pwrmgt;
                  `CPA_IDX_OSC:     s_d.rdata = s_q.osc;
                  `CPA_IDX_ADDR_LO: s_d.rdata = s_q.alo;
                  `CPA_IDX_ADDR_HI: s_d.rdata = s_q.ahi;
                  default: begin
                     s_d.rdata = 8'h00;
                     if (ld_ok && s_q.idx == `CPA_IDX_ACTIVATE) begin
                        s_d.rdata = s_q.act[s_q.ldn[LDW-1:0]];
                     end else if (ld_ok && s_q.idx >= `CPA_IDX_LD_BASE &&
                                  {24'h0000_00, woff} < LD_WIN) begin
                        s_d.rdata = s_q.mem[s_q.ldn[LDW-1:0]][woff[LWW-1:0]];
                     end
                  end
               endcase
            end
         end
      end
      // hard reset clears what the host programs except the relocation bytes, which the strap capture reloads at release
      if (hard) begin                                                  // see R1 see R15
         s_d.mode   = cpa_pkg::CPA_RUN;
         s_d.idx    = 8'h00;
         s_d.ldn    = `CPA_RST_LDN;
         s_d.pwrctl = 8'h00;
         s_d.pwrmgt = 8'h00;
         s_d.osc    = `CPA_RST_OSC;
         s_d.act    = '0;
         s_d.mem    = '0;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         s_q      <= '0;                                               // see R1
         s_q.mode <= cpa_pkg::CPA_RUN;
         s_q.osc  <= `CPA_RST_OSC;
         s_q.alo  <= `CPA_RST_ADDR_LO_S0;
         s_q.ahi  <= `CPA_RST_ADDR_HI;
         s_q.cap  <= `CPA_CAP_WAIT;
         s_q.blk  <= POR_BLOCK_CYC[CW-1:0];                            // see R17
         s_q.wreq <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign avs_readdata_o    = s_q.rdata;
   assign avs_waitrequest_o = s_q.wreq;
   assign cfg_mode_o        = (s_q.mode == cpa_pkg::CPA_CFG);
   assign port_base_o       = {s_q.ahi, s_q.alo};
   for (genvar g = 0; g < NUM_LD; g++) begin : g_act
      assign ld_active_o[g] = s_q.act[g][0];
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_por_run_state: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R1
      !$past(rstn_i) |-> !cfg_mode_o && ld_active_o == '0)
      else $error("not in run state after reset");
   a_strap_latch: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R2
      fall |=> s_q.strap == $past(s_q.strp_sy[1]))
      else $error("strap not latched at reset release");
   a_strap_base: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R3
      (s_q.cap == 2'h1 && !fall) |=>
         port_base_o == (s_q.strap ? 16'h0370 : 16'h03f0))
      else $error("wrong power-up port base");
   a_reloc_write: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R4
      (take && live && avs_write_i && hit_dat && cfg_mode_o &&
       s_q.idx == `CPA_IDX_ADDR_LO && !fall) |=> port_base_o[7:0] == $past(avs_writedata_i))
      else $error("relocation byte not applied");
   a_aen_ignored: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R5
      (take && aen_i && !hard) |=> $stable(s_q.mode) && $stable(s_q.idx) && $stable(s_q.ldn))
      else $error("aen cycle changed state");
   a_run_no_data: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R6
      (take && !cfg_mode_o && hit_dat && !hit_key && !hard) |=> $stable(s_q.ldn) && !cfg_mode_o)
      else $error("data port acted in run state");
   a_unlock_key: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R7
      (take && live && avs_write_i && hit_key && !cfg_mode_o &&
       avs_writedata_i == `CPA_KEY_UNLOCK) |=> cfg_mode_o ##1 cfg_mode_o || $past(hard))
      else $error("unlock key not taken");
   a_lock_key: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R8
      (take && live && avs_write_i && hit_key && cfg_mode_o &&
       avs_writedata_i == `CPA_KEY_LOCK) |=> !cfg_mode_o)
      else $error("lock key not taken");
   a_run_other_key: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R20
      (take && avs_write_i && !cfg_mode_o && avs_writedata_i != `CPA_KEY_UNLOCK)
         |=> !cfg_mode_o)
      else $error("run state left without unlock key");
   a_soft_reset: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R15
      (take && live && avs_write_i && hit_dat && !hit_key && cfg_mode_o &&
       s_q.idx == `CPA_IDX_CTRL && avs_writedata_i[0]) |=> s_q.ldn == 8'h00 && ld_active_o == '0)
      else $error("soft reset did not clear");
   a_key_write_only: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R16
      (take && avs_read_i && !cfg_mode_o) |=>
         avs_readdata_o == `CPA_OPEN_BUS && !avs_waitrequest_o)
      else $error("run state read not floating");
   a_block_window: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R17
      (take && s_q.blk != '0) |=> $stable(s_q.mode) && $stable(s_q.idx))
      else $error("access during power-on block");
   a_index_persist: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see R21
      (take && hit_dat && !hit_key && !hard) |=> $stable(s_q.idx))
      else $error("index changed by data access");
   a_answer_pulse: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      $fell(avs_waitrequest_o) |=> avs_waitrequest_o)
      else $error("answer longer than one cycle");
endmodule // cpa_top

/* bench/cpa_host_model.sv */
// host bus master model that drives the configuration port access block
module cpa_host_model (
   input  wire logic        mclk_i,        // block clock
   input  wire logic [7:0]  readdata_i,    // read byte, valid while waitrequest low
   input  wire logic        waitrequest_i, // low for one cycle to answer
   output logic             aen_o,         // address enable, high = cycle ignored
   output logic      [15:0] address_o,     // io address
   output logic             read_o,        // read request
   output logic             write_o,       // write request
   output logic      [7:0]  writedata_o    // write byte
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // idle bus and byte cycle
   // ----------------------------------------------------------------
   // idle: no request, aen high so nothing can decode
   initial begin
      aen_o       = 1'b1;
      address_o   = 16'h0000;
      read_o      = 1'b0;
      write_o     = 1'b0;
      writedata_o = 8'h00;
   end
   // the request stands until waitrequest is seen low; only the bench
   // timeout ends the wait, so a slow block is never hurried
   task automatic io(input logic we, input logic [15:0] a, input logic [7:0] d,
                     input logic ign, output logic [7:0] q);
      @(posedge mclk_i);
      aen_o       <= ign;
      address_o   <= a;
      writedata_o <= d;
      write_o     <= we;
      read_o      <= !we;
      do
         @(posedge mclk_i);
      while (waitrequest_i !== 1'b0);
      q = readdata_i;
      // released address and data show the inverse so stale values never look valid
      write_o     <= 1'b0;
      read_o      <= 1'b0;
      aen_o       <= 1'b1;
      address_o   <= ~a;
      writedata_o <= ~d;
   endtask
endmodule // cpa_host_model

/* bench/test_config_port_access.sv */
// self-checking bench of the configuration port access block
module test_config_port_access;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int NLD = 10;               // logical devices
   logic           mclk_i, rstn_i, bus_rst, strap, aen, rd_en, wr_en, wreq, cfg;
   logic [15:0]    addr, base, pb;        // pb: where the key port should be
   logic [7:0]     wdata, rdata, q, v;
   logic [NLD-1:0] act;
   logic [31:0]    lf = 32'h560a_0374;    // fixed seed
   logic [7:0]     dev_b [NLD];           // expected per-device byte
   int             err_total = 0;
   int             n_tests = 0;
   int             cyc = 0;
   cpa_top #(.NUM_LD(NLD), .POR_BLOCK_CYC(20)) dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
      .bus_reset_input_i(bus_rst), .strap_i(strap), .aen_i(aen), .avs_address_i(addr),
      .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .cfg_mode_o(cfg),
      .ld_active_o(act), .port_base_o(base));
   cpa_host_model host (.mclk_i(mclk_i), .readdata_i(rdata), .waitrequest_i(wreq),
      .aen_o(aen), .address_o(addr), .read_o(rd_en), .write_o(wr_en), .writedata_o(wdata));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   function automatic logic [7:0] nxt();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf[7:0];
   endfunction
   function automatic logic [15:0] exp_base(logic s);
      return s ? 16'h0370 : 16'h03F0;
   endfunction
   task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_word(string nm, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d);
      host.io(1'b1, a, d, 1'b0, q);
   endtask
   task automatic rd(logic [15:0] a, output logic [7:0] o);
      host.io(1'b0, a, 8'h00, 1'b0, o);
   endtask
   // index first, data next; the index stays for the data access
   task automatic creg_wr(logic [7:0] i, logic [7:0] d);
      wr(pb, i);
      wr(pb + 16'h0001, d);
   endtask
   task automatic creg_rd(logic [7:0] i, output logic [7:0] o);
      wr(pb, i);
      rd(pb + 16'h0001, o);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // hang guard: the whole run needs well under this many cycles
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   // ----------------------------------------------------------------
   // main sequence: unlock, access, lock in that order
   // ----------------------------------------------------------------
   initial begin
      rstn_i  = 1'b0;
      bus_rst = 1'b0;
      strap   = 1'b0;
      repeat (16) @(posedge mclk_i);
      chk_word("cfg in reset", 16'h0000, {15'h0, cfg});
      chk_word("base in reset", exp_base(1'b0), base);
      rstn_i <= 1'b1;
      wr(16'h03F0, 8'h55);
      chk_word("cfg in por block", 16'h0000, {15'h0, cfg});
      repeat (30) @(posedge mclk_i);
      pb = exp_base(1'b0);
      rd(pb, q);
      chk_byte("key port read", 8'hFF, q);
      rd(pb + 16'h0001, q);
      chk_byte("data read in run", 8'hFF, q);
      wr(pb + 16'h0001, 8'h55);
      chk_word("key at data port", 16'h0000, {15'h0, cfg});
      for (int i = 0; i < 4; i++) begin
         v = nxt();
         wr(pb, (v == 8'h55) ? 8'h54 : v);
         chk_word("other key value", 16'h0000, {15'h0, cfg});
      end
      host.io(1'b1, pb, 8'h55, 1'b1, q);
      chk_word("key with aen", 16'h0000, {15'h0, cfg});
      wr(pb, 8'h55);
      chk_word("unlock", 16'h0001, {15'h0, cfg});
      wr(pb, 8'h22);
      rd(pb, q);
      chk_byte("index readback", 8'h22, q);
      v = nxt();
      wr(pb + 16'h0001, v);
      rd(pb + 16'h0001, q);
      chk_byte("data readback", v, q);
      rd(pb + 16'h0001, q);
      chk_byte("index held", v, q);
      // each device gets its own top window byte; odd devices are activated
      for (int n = 0; n < NLD; n++) begin
         dev_b[n] = nxt();
         creg_wr(8'h07, n[7:0]);
         creg_wr(8'h7F, dev_b[n]);
         creg_wr(8'h30, {7'h00, n[0]});
      end
      repeat (2) @(posedge mclk_i);
      chk_word("activate mask", 16'h02AA, {6'h00, act});
      for (int n = 0; n < NLD; n++) begin
         creg_wr(8'h07, n[7:0]);
         creg_rd(8'h7F, q);
         chk_byte("device byte", dev_b[n], q);
         creg_rd(8'h07, q);
         chk_byte("ldn readback", n[7:0], q);
         creg_rd(8'h22, q);
         chk_byte("global with ldn", v, q);
      end
      creg_wr(8'h26, 8'h50);
      pb = 16'h0350;
      chk_word("base low moved", pb, base);
      creg_wr(8'h27, 8'h02);
      pb = 16'h0250;
      chk_word("base high moved", pb, base);
      creg_wr(8'h02, 8'h01);
      repeat (2) @(posedge mclk_i);
      chk_word("soft reset activate", 16'h0000, {6'h00, act});
      chk_word("soft reset base", pb, base);
      wr(pb, 8'h55);
      creg_rd(8'h07, q);
      chk_byte("soft reset ldn", 8'h00, q);
      creg_rd(8'h22, q);
      chk_byte("soft reset power", 8'h00, q);
      wr(pb, 8'hAA);
      chk_word("lock", 16'h0000, {15'h0, cfg});
      wr(pb, 8'h55);
      chk_word("unlock again", 16'h0001, {15'h0, cfg});
      creg_wr(8'h07, 8'h01);
      creg_wr(8'h30, 8'h01);
      // hard reset with the strap now high
      strap   <= 1'b1;
      bus_rst <= 1'b1;
      repeat (6) @(posedge mclk_i);
      bus_rst <= 1'b0;
      repeat (8) @(posedge mclk_i);
      pb = exp_base(1'b1);
      chk_word("base after hard reset", pb, base);
      chk_word("run after hard reset", 16'h0000, {15'h0, cfg});
      chk_word("devices off", 16'h0000, {6'h00, act});
      wr(pb, 8'h55);
      creg_rd(8'h26, q);
      chk_byte("reloc low reset", 8'h70, q);
      creg_rd(8'h27, q);
      chk_byte("reloc high reset", 8'h03, q);
      creg_rd(8'h07, q);
      chk_byte("ldn hard reset", 8'h00, q);
      creg_rd(8'h24, q);
      chk_byte("osc hard reset", 8'h04, q);
      // a device number past the last device owns no registers
      creg_wr(8'h07, 8'h0C);
      creg_wr(8'h7F, 8'h3C);
      creg_rd(8'h7F, q);
      chk_byte("absent device byte", 8'h00, q);
      wr(pb, 8'hAA);
      chk_word("final lock", 16'h0000, {15'h0, cfg});
      results();
   end
endmodule // test_config_port_access
